// ### hdl/ssl_regs.svh
// Purpose: shared constants for the serial shift and latch block
// Assumes: included by bare name, definitions only
// Notes: no software registers; positions index the sampled pin vector
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

`define SSL_STAGES      8
`define SSL_FIFO_DEPTH  32
`define SSL_NPINS       4
`define SSL_PIN_SER     0
`define SSL_PIN_SHIFT   1
`define SSL_PIN_LATCH   2
`define SSL_PIN_OE      3
`define SSL_PIN_RST_VAL 4'h8

`endif

// ### hdl/ssl_pkg.sv
// Purpose: types for the serial shift and latch block
// Assumes: ssl_regs.svh holds the numbers
// Notes: none
`default_nettype none
`include "ssl_regs.svh"
package ssl_pkg;
  typedef logic [`SSL_STAGES-1:0] ssl_word_t;
  typedef logic [`SSL_NPINS-1:0]  ssl_pins_t;
endpackage
`default_nettype wire

// ### hdl/ssl_fifo_if.sv
// Purpose: valid/ready carrier between the stage snapshot and the fifo
// Assumes: one clock domain
// Notes: src fills, sink drains, store is the fifo itself
`timescale 1ns/1ns
`default_nettype none
interface ssl_fifo_if #(parameter int W = 8);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport src   (output in_data, output in_valid, input in_ready);
  modport sink  (input out_data, input out_valid, output out_ready);
  modport store (input in_data, input in_valid, output in_ready,
                 output out_data, output out_valid, input out_ready);
endinterface
`default_nettype wire

// ### hdl/ssl_fifo.sv
// Purpose: word fifo with registered read stage
// Assumes: DEPTH is a power of two
// Notes: holds DEPTH words in memory plus one in the output stage
`timescale 1ns/1ns
`default_nettype none
module ssl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input wire logic   clk,
  input wire logic   rst_b,
  ssl_fifo_if.store  f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          full_reg;
  logic          out_valid_reg;
  logic [W-1:0]  out_data_reg;

  wire push       = f.in_valid & ~full_reg;
  wire stage_free = ~out_valid_reg | f.out_ready;
  wire pop        = stage_free & (cnt_reg != '0);

  assign cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign f.in_ready  = ~full_reg;
  assign f.out_valid = out_valid_reg;
  assign f.out_data  = out_data_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= f.in_data;
    end
    if (pop) begin
      out_data_reg <= mem[rd_ptr_reg];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      cnt_reg       <= '0;
      full_reg      <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_reg + AW'(push);
      rd_ptr_reg    <= rd_ptr_reg + AW'(pop);
      cnt_reg       <= cnt_next;
      full_reg      <= (cnt_next == (AW+1)'(DEPTH));
      out_valid_reg <= pop | (out_valid_reg & ~f.out_ready);
    end
  end
endmodule
`default_nettype wire

// ### hdl/ssl_top.sv
// Purpose: eight-stage serial shift register with held word and floating parallel outputs
// Assumes: pins arrive asynchronous to CLOCK and are far slower than it
// Notes: held word has no reset so that RST_B never alters it
`timescale 1ns/1ns
`default_nettype none
`include "ssl_regs.svh"
module ssl_top #(
  parameter int FIFO_DEPTH = `SSL_FIFO_DEPTH
) (
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  input  wire logic               SER_IN,
  input  wire logic               SHIFT_CLK,
  input  wire logic               LATCH_CLK,
  input  wire logic               OUT_EN_B,
  input  wire logic               WORD_HOLD,
  output var  logic               LATCH_READY,
  output var  logic               TAIL_OUT,
  output var  ssl_pkg::ssl_word_t PAR_OUT,
  output var  ssl_pkg::ssl_word_t PAR_OE
);
  import ssl_pkg::*;

  ssl_pins_t pins;
  ssl_pins_t sync1_reg;
  ssl_pins_t sync2_reg;
  ssl_pins_t sync3_reg;
  ssl_pins_t filt_reg;
  ssl_pins_t prev_reg;
  ssl_word_t stages_reg;
  ssl_word_t held_word_reg;
  ssl_word_t par_oe_reg;
  logic      latch_ready_reg;

  ssl_fifo_if #(.W(`SSL_STAGES)) word_q ();

  assign pins[`SSL_PIN_SER]   = SER_IN;
  assign pins[`SSL_PIN_SHIFT] = SHIFT_CLK;
  assign pins[`SSL_PIN_LATCH] = LATCH_CLK;
  assign pins[`SSL_PIN_OE]    = OUT_EN_B;

  // three-stage sampler, level accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `SSL_NPINS; gi++) begin : g_pin
      localparam logic RV = 1'(`SSL_PIN_RST_VAL >> gi);
      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          sync1_reg[gi] <= RV;
          sync2_reg[gi] <= RV;
          sync3_reg[gi] <= RV;
          filt_reg[gi]  <= RV;
          prev_reg[gi]  <= RV;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
          prev_reg[gi]  <= filt_reg[gi];
        end
      end
    end
  endgenerate

  wire shift_rise = filt_reg[`SSL_PIN_SHIFT] & ~prev_reg[`SSL_PIN_SHIFT];
  wire latch_rise = filt_reg[`SSL_PIN_LATCH] & ~prev_reg[`SSL_PIN_LATCH];
  wire ser_bit    = filt_reg[`SSL_PIN_SER];
  wire out_on     = ~filt_reg[`SSL_PIN_OE];
  wire take_word  = word_q.out_valid & word_q.out_ready;

  // snapshot of the stages before any shift of the same cycle
  assign word_q.in_valid  = latch_rise;
  assign word_q.in_data   = stages_reg;
  assign word_q.out_ready = ~WORD_HOLD;

  ssl_fifo #(
    .W     (`SSL_STAGES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .f     (word_q)
  );

  // shift stages, cleared at once by reset
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      stages_reg <= '0;
    end else if (shift_rise) begin
      stages_reg <= {stages_reg[`SSL_STAGES-2:0], ser_bit};
    end
  end

  // held word: loaded only from a latched snapshot, never reset
  always_ff @(posedge CLOCK) begin
    if (take_word) begin
      held_word_reg <= word_q.out_data;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      par_oe_reg      <= '0;
      latch_ready_reg <= 1'b0;
    end else begin
      par_oe_reg      <= {`SSL_STAGES{out_on}};
      latch_ready_reg <= word_q.in_ready;
    end
  end

  assign TAIL_OUT    = stages_reg[`SSL_STAGES-1];
  assign PAR_OUT     = held_word_reg;
  assign PAR_OE      = par_oe_reg;
  assign LATCH_READY = latch_ready_reg;
endmodule
`default_nettype wire

// ### dv/ssl_ctl_mdl.sv
// Purpose: serial controller driving the pin link
// Assumes: clk is the bench clock
// Notes: link period 40 cycles, clocks idle low
`timescale 1ns/1ns
`default_nettype none
module ssl_ctl_mdl (
  input  wire logic clk,
  output var  logic ser,
  output var  logic sck,
  output var  logic lck
);
  initial {ser, sck, lck} = 3'h0;
  // k[0] shift, k[1] latch; data inverted once its hold ends
  task automatic pulse(input logic [1:0] k, input logic d);
    @(posedge clk) ser <= d;
    repeat (19) @(posedge clk);
    {sck, lck} <= {k[0], k[1]};
    repeat (20) @(posedge clk);
    {ser, sck, lck} <= {!d, 2'h0};
  endtask
endmodule
`default_nettype wire

// ### dv/ssl_top_sva.sv
// Purpose: port checks
// Assumes: pins slow against CLOCK
// Notes: ages count cycles since pin rises, latch age also cleared while WORD_HOLD is high
`timescale 1ns/1ns
`default_nettype none
module ssl_top_sva (
  input wire logic       CLOCK,
  input wire logic       RST_B,
  input wire logic       SHIFT_CLK,
  input wire logic       LATCH_CLK,
  input wire logic       OUT_EN_B,
  input wire logic       WORD_HOLD,
  input wire logic       TAIL_OUT,
  input wire logic [7:0] PAR_OUT,
  input wire logic [7:0] PAR_OE
);
  logic [7:0] sa_reg;
  logic [7:0] la_reg;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  always_ff @(posedge CLOCK or negedge RST_B)
    if (!RST_B) {sa_reg, la_reg} <= 16'hffff;
    else begin
      sa_reg <= $rose(SHIFT_CLK) ? 8'h00 : sa_reg + 8'(sa_reg != 8'hff);
      la_reg <= ($rose(LATCH_CLK) || WORD_HOLD) ? 8'h00 : la_reg + 8'(la_reg != 8'hff);
    end
  AST_RST_CLEAR: assert property ($rose(RST_B) |-> !TAIL_OUT)
    else $error("tail set");
  AST_TAIL_WHEN: assert property ($changed(TAIL_OUT) |-> sa_reg inside {[8'h02:8'h08]})
    else $error("tail moved alone");
  AST_HELD_WHY: assert property ($changed(PAR_OUT) |-> la_reg <= 8'h28)
    else $error("word moved alone");
  AST_HOLD_STILL: assert property (WORD_HOLD && $past(WORD_HOLD) |-> $stable(PAR_OUT))
    else $error("word moved in stall");
  AST_OE_LEVEL: assert property ($stable(OUT_EN_B) [*8] |-> PAR_OE == {8{!OUT_EN_B}})
    else $error("enables wrong");
  AST_OE_OFF: assert property ($rose(OUT_EN_B) |-> ##[3:8] PAR_OE == 8'h00)
    else $error("not floated");
  AST_OE_SAME: assert property (PAR_OE == 8'h00 || PAR_OE == 8'hff)
    else $error("enables split");
  AST_TAIL_FREE: assert property ($changed(OUT_EN_B) && sa_reg > 8'h0c |=> $stable(TAIL_OUT) [*4])
    else $error("tail follows enable");
endmodule
bind ssl_top ssl_top_sva ssl_top_sva_i (.CLOCK, .RST_B, .SHIFT_CLK, .LATCH_CLK, .OUT_EN_B, .WORD_HOLD,
  .TAIL_OUT, .PAR_OUT, .PAR_OE);
`default_nettype wire

// ### dv/tb_ssl_top.sv
// Purpose: self-checking bench for ssl_top
// Assumes: controller model owns the serial, shift and latch pins; the bench drives OUT_EN_B
// Notes: fifo shrunk to 4 words
`timescale 1ns/1ns
`default_nettype none
module tb_ssl_top;
  import ssl_pkg::*;
  logic      clk, rst_b, oe_b, hold, rdy, tail, ser, sck, lck;
  ssl_word_t par, poe, m_held;
  ssl_word_t m_sr = 8'h00;
  ssl_word_t q[$];
  int        n_mismatch = 0, checked = 0, cyc = 0, i;
  ssl_ctl_mdl ssl_ctl_mdl_i (.clk(clk), .ser(ser), .sck(sck), .lck(lck));
  ssl_top #(.FIFO_DEPTH(4)) ssl_top_i (.CLOCK(clk), .RST_B(rst_b), .SER_IN(ser), .SHIFT_CLK(sck),
    .LATCH_CLK(lck), .OUT_EN_B(oe_b), .WORD_HOLD(hold), .LATCH_READY(rdy), .TAIL_OUT(tail),
    .PAR_OUT(par), .PAR_OE(poe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one link pulse; k[0] shifts, k[1] latches; fifo holds 4 plus 1
  task automatic step(input logic [1:0] k, input logic d);
    ssl_ctl_mdl_i.pulse(k, d);
    if (k[1] && q.size() < 5) q.push_back(m_sr);
    if (k[0]) m_sr = {m_sr[6:0], d};
    while (!hold && q.size() > 0) m_held = q.pop_front();
    chk({7'h0, tail}, {7'h0, m_sr[7]});
    chk({7'h0, rdy}, {7'h0, q.size() < 5});
    if (k != 2'h1) chk(par, m_held);
  endtask
  task automatic shift8();
    for (i = 0; i < 8; i++) step(2'h1, 1'($urandom));
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {rst_b, oe_b, hold} = 3'h0;
    void'($urandom(91926));
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge clk);
    repeat (3) begin
      shift8();
      step(2'h2, 1'h0);
    end
    $display("words done");
    for (i = 0; i < 8; i++) step(2'h1, 1'h1);
    rst_b <= 1'h0;
    #1 chk({7'h0, tail}, 8'h00);
    chk(par, m_held);
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    m_sr = 8'h00;
    repeat (8) @(posedge clk);
    chk(par, m_held);
    chk(poe, 8'hff);
    step(2'h1, 1'h1);
    $display("reset done");
    oe_b <= 1'h1;
    repeat (8) @(posedge clk);
    chk(poe, 8'h00);
    shift8();
    step(2'h3, 1'h1);
    oe_b <= 1'h0;
    repeat (8) @(posedge clk);
    chk(poe, 8'hff);
    $display("enable done");
    hold <= 1'h1;
    repeat (7) begin
      step(2'h1, 1'($urandom));
      step(2'h2, 1'h0);
    end
    hold <= 1'h0;
    step(2'h0, 1'h0);
    $display("fill done");
    conclude();
  end
endmodule
`default_nettype wire
